/* File: design/icl_msg_build.sv */
// Composes the outgoing message from the command words
`timescale 1ns/1ps
`default_nettype none

module icl_msg_build
  import icl_pkg::*;
#(
  parameter logic [7:0] SELF_ID = 8'h00
)(
  input  wire icl_pkg::icl_cmd_s cmd,
  input  wire logic [7:0]        target_id_field,
  output icl_pkg::icl_msg_s      msg
);
  import icl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Target selection from the shorthand
  always_comb
  begin
    msg.vector       = cmd.vector;
    msg.message_kind = cmd.message_kind;
    msg.trigger_kind = cmd.trigger_kind;
    msg.level        = cmd.level;
    msg.logical      = cmd.target_addressing;
    msg.excl_self    = 1'b0;
    msg.dest_id      = target_id_field;
    if (cmd.target_shorthand == ICL_SH_SELF)
    begin
      msg.dest_id = SELF_ID;
      msg.logical = 1'b0;
    end
    else if (cmd.target_shorthand == ICL_SH_ALL_INCL)
    begin
      msg.dest_id = ICL_DEST_ALL;
      msg.logical = 1'b0;
    end
    else if (cmd.target_shorthand == ICL_SH_ALL_EXCL)
    begin
      msg.dest_id   = ICL_DEST_ALL;
      msg.excl_self = 1'b1;
      msg.logical   = 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: design/icl_top.sv */
// Interrupt command word low: register slave, message launch and status
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Shorthand 00 field, 01 self, 10 all including self, 11 all excluding self.
// - All-excluding-self sends an all-ones destination encoding.
// - Broadcast shorthands force physical addressing, ignoring the addressing bit.
// - Remote fetch state reads 00 invalid, 01 pending, 10 done; never 11.
// - Bit 15 trigger kind: 0 edge, 1 level.
// - Bit 14 level: 0 deasserted, 1 asserted.
// - Bit 12 reads 1 until the message is accepted or rejected, then 0.
// - Bit 11 addressing: 0 physical, 1 logical.
// - Bits 10:8 message kind: fixed, lowest, mgmt, fetch, nmi, restart, startup.
// - Bits 7:0 hold the vector carried in the message.
// - Shorthand 00 takes the destination from high word bits 31:24.
// - Fixed or lowest message with vector 00h-0Fh records a bad vector error.
// - A message accepted by nobody records an unaccepted error.
module icl_top
  import icl_pkg::*;
#(
  parameter int         ADDR_W  = 12,
  parameter logic [7:0] SELF_ID = 8'h00  // Arbitrary value
)(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [31:0]            rdata_r,
  output logic                   irq_r,
  output icl_pkg::icl_msg_s      msg_r,
  output logic                   msg_valid_r,
  input  wire logic              link_accept,
  input  wire logic              link_reject
);
  import icl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  if (ADDR_W < 12)
  begin : g_chk
    $error("ADDR_W must be at least 12");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address match helper
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  // Fixed and lowest priority refuse vectors below the minimum
  function automatic logic bad_vec(input icl_cmd_s c);
    bad_vec = ((c.message_kind == ICL_KIND_FIXED) || (c.message_kind == ICL_KIND_LOWEST))
              && (c.vector < ICL_VEC_MIN);
  endfunction

  // Command fields taken from a low word image; shared by write decode and reset
  function automatic icl_cmd_s cmd_of(input logic [31:0] w);
    icl_cmd_s c;
    c.target_shorthand  = w[ICL_POS_SHORT +: 2];
    c.trigger_kind      = w[ICL_POS_TRIGGER];
    c.level             = w[ICL_POS_LEVEL];
    c.target_addressing = w[ICL_POS_LOGICAL];
    c.message_kind      = w[ICL_POS_KIND +: 3];
    c.vector            = w[ICL_POS_VEC +: 8];
    cmd_of = c;
  endfunction

  // Stored fields after reset, cut out of the documented reset word
  localparam icl_cmd_s CMD_RST = cmd_of(ICL_RST_CMD_LO);

  icl_cmd_s                cmd_r;
  logic [7:0]              dest_r;
  logic                    pending_r;
  icl_fetch_e              fetch_r;
  logic [7:0]              err_int_r;
  logic [7:0]              err_vis_r;
  logic [ICL_EVT_W-1:0]    evt_r;
  logic [ICL_EVT_W-1:0]    mask_r;
  icl_cmd_s                wr_cmd;
  icl_msg_s                built;
  logic                    wr_lo;
  logic                    launch;
  logic                    launch_bad;
  logic                    mapped;
  logic                    done_ok;
  logic                    done_bad;
  logic [ICL_EVT_W-1:0]    evt_set;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode and launch qualification
  always_comb
  begin
    wr_cmd     = cmd_of(wdata);
    wr_lo      = wr && hit(addr, ICL_OFF_CMD_LO) && !pending_r;
    launch_bad = wr_lo && bad_vec(wr_cmd);
    launch     = wr_lo && !bad_vec(wr_cmd);
  end

  // Delivery outcome of the outstanding message
  assign done_ok  = msg_valid_r && link_accept;
  assign done_bad = msg_valid_r && !link_accept && link_reject;

  // Message composer
  icl_msg_build #(
    .SELF_ID (SELF_ID)
  ) u_build (
    .cmd             (wr_cmd),
    .target_id_field (dest_r),
    .msg             (built)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command word low fields; refused while a message is pending
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cmd_r <= CMD_RST;
    else if (wr_lo)
      cmd_r <= wr_cmd;
  end

  // Command word high target id field
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dest_r <= ICL_RST_DEST;
    else if (wr && hit(addr, ICL_OFF_CMD_HI))
      dest_r <= wdata[ICL_POS_DEST +: 8];
  end

  // Outgoing message held until the far side answers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      msg_valid_r <= 1'b0;
      msg_r       <= '0;
    end
    else if (launch)
    begin
      msg_valid_r <= 1'b1;
      msg_r       <= built;
    end
    else if (done_ok || done_bad)
      msg_valid_r <= 1'b0;
  end

  // Delivery pending flag
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pending_r <= 1'b0;
    else if (launch)
      pending_r <= 1'b1;
    else if (done_ok || done_bad)
      pending_r <= 1'b0;
  end

  // Remote fetch state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fetch_r <= ICL_FETCH_INVALID;
    else if (launch && (wr_cmd.message_kind == ICL_KIND_FETCH))
      fetch_r <= ICL_FETCH_PENDING;
    else if (done_ok && (msg_r.message_kind == ICL_KIND_FETCH))
      fetch_r <= ICL_FETCH_DONE;
    else if (done_bad && (msg_r.message_kind == ICL_KIND_FETCH))
      fetch_r <= ICL_FETCH_INVALID;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mapped addresses
  assign mapped = hit(addr, ICL_OFF_ERR_STAT) || hit(addr, ICL_OFF_CMD_LO) ||
                  hit(addr, ICL_OFF_CMD_HI) || hit(addr, ICL_OFF_EVT_STAT) ||
                  hit(addr, ICL_OFF_EVT_MASK);

  // Internal error state; new errors win over the load-and-clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      err_int_r <= 8'h00;
    else
    begin
      if (wr && hit(addr, ICL_OFF_ERR_STAT))
        err_int_r <= 8'h00;
      if (launch_bad)
        err_int_r[ICL_ERR_BADVEC] <= 1'b1;
      if (done_bad)
        err_int_r[ICL_ERR_UNACC] <= 1'b1;
      if ((wr || rd) && !mapped)
        err_int_r[ICL_ERR_BADADDR] <= 1'b1;
    end
  end

  // Visible error status loads on any write to it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      err_vis_r <= 8'h00;
    else if (wr && hit(addr, ICL_OFF_ERR_STAT))
      err_vis_r <= err_int_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status: sticky, cleared by read, set wins
  always_comb
  begin
    evt_set                 = '0;
    evt_set[ICL_EVT_ACCEPT] = done_ok;
    evt_set[ICL_EVT_UNACC]  = done_bad;
    evt_set[ICL_EVT_BADVEC] = launch_bad;
    evt_set[ICL_EVT_FETCH]  = (done_ok || done_bad) && (msg_r.message_kind == ICL_KIND_FETCH);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      evt_r <= '0;
    else if (rd && hit(addr, ICL_OFF_EVT_STAT))
      evt_r <= evt_set;
    else
      evt_r <= evt_r | evt_set;
  end

  // Event mask
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mask_r <= '0;
    else if (wr && hit(addr, ICL_OFF_EVT_MASK))
      mask_r <= wdata[ICL_EVT_W-1:0];
  end

  // Interrupt output, one cycle behind the status
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irq_r <= 1'b0;
    else
      irq_r <= |(evt_r & mask_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= 32'h0000_0000;
    else if (!rd)
      rdata_r <= 32'h0000_0000;
    else if (hit(addr, ICL_OFF_CMD_LO))
    begin
      rdata_r <= 32'h0000_0000;
      rdata_r[ICL_POS_SHORT +: 2]  <= cmd_r.target_shorthand;
      rdata_r[ICL_POS_FETCH +: 2]  <= fetch_r;
      rdata_r[ICL_POS_TRIGGER]     <= cmd_r.trigger_kind;
      rdata_r[ICL_POS_LEVEL]       <= cmd_r.level;
      rdata_r[ICL_POS_PENDING]     <= pending_r;
      rdata_r[ICL_POS_LOGICAL]     <= cmd_r.target_addressing;
      rdata_r[ICL_POS_KIND +: 3]   <= cmd_r.message_kind;
      rdata_r[ICL_POS_VEC +: 8]    <= cmd_r.vector;
    end
    else if (hit(addr, ICL_OFF_CMD_HI))
      rdata_r <= {dest_r, 24'h000000};
    else if (hit(addr, ICL_OFF_ERR_STAT))
      rdata_r <= {24'h000000, err_vis_r};
    else if (hit(addr, ICL_OFF_EVT_STAT))
      rdata_r <= {{(32-ICL_EVT_W){1'b0}}, evt_r};
    else if (hit(addr, ICL_OFF_EVT_MASK))
      rdata_r <= {{(32-ICL_EVT_W){1'b0}}, mask_r};
    else
      rdata_r <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_launch_wr;
    wr && hit(addr, ICL_OFF_CMD_LO) && !pending_r && !bad_vec(wr_cmd);
  endsequence

  sequence s_msg_out;
    msg_valid_r && pending_r;
  endsequence

  property p_launch;
    s_launch_wr |=> s_msg_out;
  endproperty
  a_launch: assert property (p_launch) else $error("Low word write did not launch");

  property p_pend_hold;
    pending_r && !link_accept && !link_reject |=> pending_r && msg_valid_r;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("Pending dropped early");

  property p_accept_clear;
    msg_valid_r && link_accept |=> !pending_r && !msg_valid_r;
  endproperty
  a_accept_clear: assert property (p_accept_clear) else $error("Pending not cleared");

  property p_all_excl;
    msg_valid_r && msg_r.excl_self |-> msg_r.dest_id == 8'hFF && !msg_r.logical;
  endproperty
  a_all_excl: assert property (p_all_excl) else $error("Broadcast encoding wrong");

  property p_phys;
    s_launch_wr ##0 wdata[ICL_POS_SHORT+1] |=> !msg_r.logical;
  endproperty
  a_phys: assert property (p_phys) else $error("Broadcast used logical mode");

  property p_self;
    s_launch_wr ##0 (wdata[ICL_POS_SHORT +: 2] == 2'h1) |=> msg_r.dest_id == SELF_ID;
  endproperty
  a_self: assert property (p_self) else $error("Self target wrong");

  property p_field_dest;
    s_launch_wr ##0 (wdata[ICL_POS_SHORT +: 2] == 2'h0) |=> msg_r.dest_id == $past(dest_r);
  endproperty
  a_field_dest: assert property (p_field_dest) else $error("Field target wrong");

  property p_bad_vec;
    wr && hit(addr, ICL_OFF_CMD_LO) && !pending_r && bad_vec(wr_cmd)
      |=> err_int_r[ICL_ERR_BADVEC] && !msg_valid_r && !pending_r;
  endproperty
  a_bad_vec: assert property (p_bad_vec) else $error("Bad vector not flagged");

  property p_unacc;
    msg_valid_r && link_reject && !link_accept
      |=> err_int_r[ICL_ERR_UNACC] && evt_r[ICL_EVT_UNACC];
  endproperty
  a_unacc: assert property (p_unacc) else $error("Unaccepted not flagged");

  property p_fetch_code;
    fetch_r != 2'h3;
  endproperty
  a_fetch_code: assert property (p_fetch_code) else $error("Reserved fetch state");

  property p_rd_pending;
    rd && hit(addr, ICL_OFF_CMD_LO) |=> rdata_r[ICL_POS_PENDING] == $past(pending_r);
  endproperty
  a_rd_pending: assert property (p_rd_pending) else $error("Pending read wrong");

endmodule

`default_nettype wire

/* File: shared/icl_pkg.sv */
// Package for the interprocessor interrupt command block: offsets, fields, types
package icl_pkg;

  // Register byte offsets
  localparam logic [11:0] ICL_OFF_ERR_STAT = 12'h280;
  localparam logic [11:0] ICL_OFF_CMD_LO   = 12'h300;
  localparam logic [11:0] ICL_OFF_CMD_HI   = 12'h310;
  localparam logic [11:0] ICL_OFF_EVT_STAT = 12'h3F0;
  localparam logic [11:0] ICL_OFF_EVT_MASK = 12'h3F4;

  // Reset values
  localparam logic [31:0] ICL_RST_CMD_LO = 32'h0000_0000;
  localparam logic [7:0]  ICL_RST_DEST   = 8'h00;

  // Command word low field positions
  localparam int ICL_POS_VEC      = 0;
  localparam int ICL_POS_KIND     = 8;
  localparam int ICL_POS_LOGICAL  = 11;
  localparam int ICL_POS_PENDING  = 12;
  localparam int ICL_POS_LEVEL    = 14;
  localparam int ICL_POS_TRIGGER  = 15;
  localparam int ICL_POS_FETCH    = 16;
  localparam int ICL_POS_SHORT    = 18;
  // Command word high: target id field position
  localparam int ICL_POS_DEST     = 24;

  // Error status bit positions
  localparam int ICL_ERR_UNACC    = 2;
  localparam int ICL_ERR_BADVEC   = 5;
  localparam int ICL_ERR_BADADDR  = 7;

  // Event status / mask bit positions
  localparam int ICL_EVT_ACCEPT   = 0;
  localparam int ICL_EVT_UNACC    = 1;
  localparam int ICL_EVT_BADVEC   = 2;
  localparam int ICL_EVT_FETCH    = 3;
  localparam int ICL_EVT_W        = 4;

  // Vectors below this are illegal for fixed and lowest priority
  localparam logic [7:0] ICL_VEC_MIN   = 8'h10;
  // Broadcast destination encoding
  localparam logic [7:0] ICL_DEST_ALL  = 8'hFF;

  typedef enum logic [2:0] {
    ICL_KIND_FIXED   = 3'h0,
    ICL_KIND_LOWEST  = 3'h1,
    ICL_KIND_MGMT    = 3'h2,
    ICL_KIND_FETCH   = 3'h3,
    ICL_KIND_NMI     = 3'h4,
    ICL_KIND_RESTART = 3'h5,
    ICL_KIND_STARTUP = 3'h6
  } icl_kind_e;

  typedef enum logic [1:0] {
    ICL_SH_FIELD    = 2'h0,
    ICL_SH_SELF     = 2'h1,
    ICL_SH_ALL_INCL = 2'h2,
    ICL_SH_ALL_EXCL = 2'h3
  } icl_short_e;

  typedef enum logic [1:0] {
    ICL_FETCH_INVALID = 2'h0,
    ICL_FETCH_PENDING = 2'h1,
    ICL_FETCH_DONE    = 2'h2
  } icl_fetch_e;

  // Software-written fields of the command word low
  typedef struct packed {
    logic [1:0] target_shorthand;
    logic       trigger_kind;
    logic       level;
    logic       target_addressing;
    logic [2:0] message_kind;
    logic [7:0] vector;
  } icl_cmd_s;

  // Message as presented to the other controllers
  typedef struct packed {
    logic [7:0] vector;
    logic [2:0] message_kind;
    logic       trigger_kind;
    logic       level;
    logic       logical;
    logic [7:0] dest_id;
    logic       excl_self;
  } icl_msg_s;

endpackage

/* File: tb/icl_peer_model.sv */
// Model of the peer controllers that answer offered messages
`timescale 1ns/1ps
`default_nettype none

module icl_peer_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       msg_valid,
  input  wire logic       reject_mode,
  input  wire logic [7:0] delay,
  output logic            link_accept,
  output logic            link_reject
);
  logic [7:0] wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // One answer pulse per offered message, after the chosen delay
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_r      <= 8'h00;
      link_accept <= 1'b0;
      link_reject <= 1'b0;
    end
    else
    begin
      link_accept <= 1'b0;
      link_reject <= 1'b0;
      if (!msg_valid)
        wait_r <= 8'h00;
      else if (wait_r != 8'hFF)
      begin
        wait_r <= wait_r + 8'h01;
        if (wait_r == delay)
        begin
          link_accept <= !reject_mode;
          link_reject <= reject_mode;
        end
      end
    end
  end
endmodule

`default_nettype wire

/* File: tb/icl_top_tb.sv */
// Self-checking bench for the interrupt command word block
`timescale 1ns/1ps
`default_nettype none

module icl_top_tb;
  import icl_pkg::*;

  typedef struct {logic [31:0] cmd; logic [7:0] dest; logic [22:0] exp;} icl_row_s;

  logic        clk, nrst, wr, rd, rej, acc_p, rej_p, irq_r, msg_valid_r, fetch;
  logic [11:0] addr;
  logic [31:0] wdata, rdata_r, d;
  logic [7:0]  dly;
  icl_msg_s    msg_r;
  int          failures, checked;
  icl_row_s    rows [9];

  icl_top #(.SELF_ID(8'h05)) dut (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .irq_r(irq_r), .msg_r(msg_r), .msg_valid_r(msg_valid_r),
    .link_accept(acc_p), .link_reject(rej_p)
  );

  icl_peer_model peer (
    .clk(clk), .nrst(nrst), .msg_valid(msg_valid_r), .reject_mode(rej),
    .delay(dly), .link_accept(acc_p), .link_reject(rej_p)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata_r;
  endtask

  // High word first, then the launching low word
  task automatic launch(input logic [7:0] dst, input logic [31:0] cmd);
    wr_reg(ICL_OFF_CMD_HI, {dst, 24'h0});
    wr_reg(ICL_OFF_CMD_LO, cmd);
    @(negedge clk);
  endtask

  task automatic wait_idle();
    for (int n = 0; n < 40; n++)
    begin
      @(negedge clk);
      if (msg_valid_r === 1'b0)
        break;
    end
    chk(msg_valid_r, 0, "answer");
  endtask

  task automatic final_report();
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #400000;
    failures++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    // Valid combinations only, every kind and shorthand
    rows = '{
      '{32'h0000_0831, 8'h12, {8'h31, 3'h0, 3'b001, 8'h12, 1'b0}},
      '{32'h0004_C040, 8'h77, {8'h40, 3'h0, 3'b110, 8'h05, 1'b0}},
      '{32'h000C_0922, 8'h77, {8'h22, 3'h1, 3'b000, 8'hFF, 1'b1}},
      '{32'h0000_0200, 8'h34, {8'h00, 3'h2, 3'b000, 8'h34, 1'b0}},
      '{32'h0008_0855, 8'h77, {8'h55, 3'h0, 3'b000, 8'hFF, 1'b0}},
      '{32'h000C_C402, 8'h77, {8'h02, 3'h4, 3'b110, 8'hFF, 1'b1}},
      '{32'h0000_0D00, 8'h7E, {8'h00, 3'h5, 3'b001, 8'h7E, 1'b0}},
      '{32'h0000_069A, 8'h01, {8'h9A, 3'h6, 3'b000, 8'h01, 1'b0}},
      '{32'h0000_0310, 8'h02, {8'h10, 3'h3, 3'b000, 8'h02, 1'b0}}};
    failures = 0;
    checked = 0;
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 12'h000;
    wdata = 32'h0000_0000;
    rej = 1'b0;
    dly = 8'h06;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(ICL_OFF_CMD_LO, d);
    chk(d, ICL_RST_CMD_LO, "reset word");
    chk(msg_valid_r, 0, "reset offer");
    // Table of messages
    foreach (rows[i])
    begin
      launch(rows[i].dest, rows[i].cmd);
      fetch = (rows[i].cmd[10:8] === 3'h3);
      chk(msg_valid_r, 1, "offer");
      chk({9'h0, msg_r}, {9'h0, rows[i].exp}, "message");
      rd_reg(ICL_OFF_CMD_LO, d);
      chk(d[12], 1, "pending");
      if (fetch)
        chk(d[17:16], 2'h1, "fetch pending");
      wait_idle();
      rd_reg(ICL_OFF_CMD_LO, d);
      chk(d & (fetch ? 32'h000F_DFFF : 32'h000C_DFFF),
          rows[i].cmd | (fetch ? 32'h0002_0000 : 32'h0), "stored");
    end
    // Interrupt raised, masked and cleared
    rd_reg(ICL_OFF_EVT_STAT, d);
    chk(d & 32'hF, (1 << ICL_EVT_ACCEPT) | (1 << ICL_EVT_FETCH), "accept events");
    launch(8'h12, 32'h0000_0031);
    wait_idle();
    repeat (2) @(negedge clk);
    chk(irq_r, 0, "masked irq");
    wr_reg(ICL_OFF_EVT_MASK, 32'h0000_000F);
    repeat (3) @(negedge clk);
    chk(irq_r, 1, "raised irq");
    rd_reg(ICL_OFF_EVT_STAT, d);
    repeat (3) @(negedge clk);
    chk(irq_r, 0, "cleared irq");
    // Rejected remote fetch, bad vector, unmapped read
    rej = 1'b1;
    launch(8'h02, 32'h0000_0310);
    wait_idle();
    rej = 1'b0;
    rd_reg(ICL_OFF_CMD_LO, d);
    chk(d[17:12], 6'h00, "rejected fetch");
    launch(8'h02, 32'h0000_000F);
    chk(msg_valid_r, 0, "bad vector held");
    rd_reg(12'h3FC, d);
    chk(d, 0, "unmapped read");
    wr_reg(ICL_OFF_ERR_STAT, 32'h0);
    rd_reg(ICL_OFF_ERR_STAT, d);
    chk(d, (1 << ICL_ERR_UNACC) | (1 << ICL_ERR_BADVEC) | (1 << ICL_ERR_BADADDR), "errors");
    wr_reg(ICL_OFF_ERR_STAT, 32'h0);
    rd_reg(ICL_OFF_ERR_STAT, d);
    chk(d, 0, "errors cleared");
    chk(irq_r, 1, "error events irq");
    rd_reg(ICL_OFF_EVT_STAT, d);
    chk(d & 32'hF, (1 << ICL_EVT_UNACC) | (1 << ICL_EVT_BADVEC) |
        (1 << ICL_EVT_FETCH), "error events");
    // Write to the low word while a message is pending is refused
    dly = 8'd20;
    launch(8'h12, 32'h0000_0031);
    wr_reg(ICL_OFF_CMD_LO, 32'h0000_0842);
    @(negedge clk);
    chk(msg_r.vector, 8'h31, "refused write");
    wait_idle();
    rd_reg(ICL_OFF_CMD_LO, d);
    chk(d & 32'h000C_DFFF, 32'h0000_0031, "kept word");
    // Reset in mid-flight drops the offer, the word and the interrupt
    launch(8'h12, 32'h0000_0031);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk(msg_valid_r, 0, "mid-run reset offer");
    chk(irq_r, 0, "mid-run reset irq");
    rd_reg(ICL_OFF_CMD_LO, d);
    chk(d, ICL_RST_CMD_LO, "mid-run reset word");
    final_report();
  end
endmodule

`default_nettype wire
